// file: bench/test_analog_comparator_control.sv
// self-checking bench for the analog comparator control block
`timescale 1ns/100ps
module test_analog_comparator_control;
  logic                clk;
  logic                reset;
  acc_pkg::acc_bus_s   bus;
  logic [7:0]          rdata;
  logic                raw;
  logic                gie;
  logic                vec;
  logic                conv_on;
  logic [5:0]          chan;
  logic [10:0]         pin_in;
  logic                ref_in;
  acc_pkg::acc_analog_s analog;
  logic                irq;
  logic [10:0]         pin_off;
  logic                ref_off;
  logic [10:0]         pin_rd;
  logic                ref_rd;
  logic [7:0]          d;
  int                  bad_count;
  int                  check_count;
  int                  cyc = 0;
  logic [3:0]          tbl [8] = '{4'h1, 4'h2, 4'h4, 4'h6,
                                   4'h8, 4'h9, 4'h9, 4'h9};

  acc_control dut (
    .clk                      (clk),
    .reset                    (reset),
    .bus                      (bus),
    .rdata                    (rdata),
    .comparator_raw           (raw),
    .global_irq_enable        (gie),
    .irq_vector_taken         (vec),
    .converter_on             (conv_on),
    .converter_channel_select (chan),
    .pin_digital_in           (pin_in),
    .analog                   (analog),
    .irq_request              (irq),
    .analog_pin_input_off     (pin_off),
    .reference_pin_input_off  (ref_off),
    .pin_digital_read         (pin_rd),
    .reference_digital_read   (ref_rd),
    .reference_digital_in     (ref_in)
  );

  //////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask : rd

  task automatic set_raw(input logic v);
    @(posedge clk);
    raw <= v;
    repeat (5) @(posedge clk);
    #1;
  endtask : set_raw

  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    reset = 1'b1; bus = '0; raw = 0; gie = 0; vec = 0; conv_on = 0;
    chan = '0; pin_in = '0; ref_in = 0;
    bad_count = 0; check_count = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    foreach (tbl[i]) begin
      rd({5'h00, i[2:0]} + 8'h01, d);
      if (i < 4) chk("reset_value", 8'h00, d);
    end
    rd(8'h08, d); chk("ctrl_reset", 8'h00, d);
    rd(8'h09, d); chk("sel_reset", 8'h00, d);
    wr(8'h05, 8'hFF);
    rd(8'h05, d); chk("unmapped", 8'h00, d);
    $display("test reset_and_map done");

    @(posedge clk) pin_in <= 11'h7FF;
    ref_in <= 1'b1;
    wr(8'h01, 8'hFF); rd(8'h01, d); chk("dis_lo", 8'hFF, d);
    wr(8'h02, 8'hFF); rd(8'h02, d); chk("dis_hi", 8'hF0, d);
    chk("pin_off_all", 11'h7FF, pin_off);
    chk("pin_rd_all", 11'h000, pin_rd);
    chk("ref_rd_off", 1'b0, ref_rd);
    wr(8'h01, 8'h0A); wr(8'h02, 8'h50);
    chk("pin_off_mix", 11'h282, pin_off);
    chk("pin_rd_mix", 11'h57D, pin_rd);
    chk("ref_off", 1'b1, ref_off);
    wr(8'h01, 8'h00);
    chk("ref_rd_on", 1'b1, ref_rd);
    $display("test pin_disable done");

    wr(8'h09, 8'hFF); rd(8'h09, d); chk("sel_rw", 8'hC7, d);
    chk("hyst_big", 2'b11, {analog.hyst_on, analog.hyst_large});
    wr(8'h09, 8'h80);
    chk("hyst_small", 2'b10, {analog.hyst_on, analog.hyst_large});
    wr(8'h09, 8'h40);
    chk("hyst_off", 1'b0, analog.hyst_on);
    for (int s = 0; s < 8; s++) begin
      wr(8'h09, s[7:0]);
      chk("pin_table", tbl[s], {analog.pos_pin, analog.neg_pin});
    end
    $display("test hysteresis_and_select done");

    @(posedge clk) chan <= 6'h0A;
    wr(8'h08, 8'hC4); wr(8'h09, 8'h02);
    chk("pwr_bg", 2'b11, {analog.power_off, analog.bandgap_sel});
    chk("conv_neg", 1'b1, analog.neg_from_conv);
    chk("conv_ch", 6'h0A, analog.neg_channel);
    chk("conv_pos1", acc_pkg::PIN_ONE, analog.pos_pin);
    wr(8'h09, 8'h04);
    chk("conv_pos2", acc_pkg::PIN_TWO, analog.pos_pin);
    @(posedge clk) conv_on <= 1'b1;
    @(posedge clk) #1;
    chk("conv_busy", 1'b0, analog.neg_from_conv);
    chk("busy_neg", acc_pkg::PIN_ZERO, analog.neg_pin);
    rd(8'h08, d); chk("ctrl_rb", 8'hC4, d);
    wr(8'h08, 8'h00);
    chk("pwr_bg_off", 2'b00, {analog.power_off, analog.bandgap_sel});
    $display("test steering done");

    for (int m = 0; m < 4; m++) begin
      wr(8'h08, 8'h10 | m[7:0]);
      set_raw(1'b1);
      rd(8'h08, d); chk("result_hi", 1'b1, d[5]);
      chk("flag_rise", (m == 0 || m == 3), d[4]);
      wr(8'h08, 8'h10 | m[7:0]);
      set_raw(1'b0);
      rd(8'h08, d); chk("result_lo", 1'b0, d[5]);
      chk("flag_fall", (m == 0 || m == 2), d[4]);
    end
    $display("test event_modes done");

    @(posedge clk) gie <= 1'b1;
    wr(8'h08, 8'h1B);
    set_raw(1'b1);
    chk("irq_on", 1'b1, irq);
    @(posedge clk) gie <= 1'b0;
    @(posedge clk) #1 chk("irq_gie", 1'b0, irq);
    @(posedge clk) gie <= 1'b1;
    wr(8'h08, 8'h03);
    #1 chk("irq_en_off", 1'b0, irq);
    rd(8'h08, d); chk("flag_w0", 1'b1, d[4]);
    wr(8'h08, 8'h0B);
    #1 chk("irq_back", 1'b1, irq);
    @(posedge clk) vec <= 1'b1;
    @(posedge clk) vec <= 1'b0;
    #1 chk("irq_vec", 1'b0, irq);
    set_raw(1'b0);
    set_raw(1'b1);
    chk("irq_again", 1'b1, irq);
    wr(8'h08, 8'h1B);
    repeat (5) @(posedge clk);
    rd(8'h08, d); chk("flag_w1", 1'b0, d[4]);
    chk("irq_clr", 1'b0, irq);
    $display("test interrupt done");
    end_of_test();
  end
endmodule : test_analog_comparator_control

// file: hdl/acc_control.sv
// analog comparator control, status, event flag and pin disable registers
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
// What this block does
// R01 - power-off bit set removes comparator power
// R02 - software clears irq enable before changing power-off bit
// R03 - bandgap bit routes internal reference to positive input
// R04 - result bit is comparator output after two-flop synchroniser
// R05 - flag set when synchronised output change matches event mode
// R06 - irq request only with flag, enable and global enable set
// R07 - flag cleared by vector taken or by writing one
// R08 - mux bit with converter off gives converter mux negative input
// R09 - mode 00 toggle, 01 reserved, 10 falling, 11 rising
// R10 - software disables irq before changing event mode
// R11 - hysteresis bit switches comparator hysteresis on
// R12 - hysteresis amount bit chooses small or large setting
// R13 - three-bit select chooses positive and negative comparator pins
// R14 - plain pin table for select codes when converter path unused
// R15 - converter channels 0..10 negative, select picks positive pin
// R16 - analog pin disable bit turns off buffer, input reads zero
// R17 - reference pin disable bit turns off its buffer likewise
// R18 - software should disable unused analog pin buffers
// R19 - upper disable register holds channels 7..10, low nibble zero
// R20 - edge detector compares current and previous sample each clock
module acc_control (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire acc_pkg::acc_bus_s      bus,
  output logic [acc_pkg::DATA_W-1:0]  rdata,
  input  wire logic                   comparator_raw,
  input  wire logic                   global_irq_enable,
  input  wire logic                   irq_vector_taken,
  input  wire logic                   converter_on,
  input  wire logic [acc_pkg::CH_W-1:0] converter_channel_select,
  input  wire logic [10:0]            pin_digital_in,
  output acc_pkg::acc_analog_s        analog,
  output logic                        irq_request,
  output logic [10:0]                 analog_pin_input_off,
  output logic                        reference_pin_input_off,
  output logic [10:0]                 pin_digital_read,
  output logic                        reference_digital_read,
  input  wire logic                   reference_digital_in
);

  logic                 comparator_power_off;
  logic                 bandgap_positive_select;
  logic                 comparator_event_flag;
  logic                 comparator_irq_enable;
  logic                 converter_mux_for_negative;
  logic [1:0]           event_mode;
  logic                 hysteresis_on;
  logic                 hysteresis_amount;
  logic [2:0]           comparator_input_select;
  logic [7:0]           pin_input_disable_low;
  logic [7:0]           pin_input_disable_high;
  logic                 sync_first;
  logic                 comparator_result;
  logic                 result_prev;
  logic                 event_hit;
  logic                 flag_write_clear;
  logic                 next_flag;
  logic [7:0]           next_rdata;

  function automatic logic is_write(input acc_pkg::acc_bus_s b,
                                    input logic [7:0] ofs);
    is_write = b.wr && (b.addr == ofs);
  endfunction : is_write

  //////////////////////////////////////////////////////////////////////////
  // control and disable registers

  always_ff @(posedge clk) begin
    if (reset) begin
      comparator_power_off       <= 1'b0;
      bandgap_positive_select    <= 1'b0;
      comparator_irq_enable      <= 1'b0;
      converter_mux_for_negative <= 1'b0;
      event_mode                 <= acc_pkg::ACC_MODE_TOGGLE;
    end else if (is_write(bus, acc_pkg::OFS_CTRL_STATUS)) begin
      comparator_power_off       <= bus.wdata[acc_pkg::BIT_POWER_OFF]; // R01
      bandgap_positive_select    <= bus.wdata[acc_pkg::BIT_BANDGAP];   // R03
      comparator_irq_enable      <= bus.wdata[acc_pkg::BIT_IRQ_EN];    // R06
      converter_mux_for_negative <= bus.wdata[acc_pkg::BIT_MUX_NEG];   // R08
      event_mode <= bus.wdata[acc_pkg::BIT_MODE_HI:acc_pkg::BIT_MODE_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hysteresis_on           <= 1'b0;
      hysteresis_amount       <= 1'b0;
      comparator_input_select <= acc_pkg::SEL_RESET;
    end else if (is_write(bus, acc_pkg::OFS_INPUT_HYST)) begin
      hysteresis_on           <= bus.wdata[acc_pkg::BIT_HYST_ON];  // R11
      hysteresis_amount       <= bus.wdata[acc_pkg::BIT_HYST_AMT]; // R12
      comparator_input_select <= bus.wdata[acc_pkg::SEL_W-1:0];    // R13
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_input_disable_low  <= acc_pkg::RESET_BYTE;
      pin_input_disable_high <= acc_pkg::RESET_BYTE;
    end else begin
      if (is_write(bus, acc_pkg::OFS_PIN_OFF_LO))
        pin_input_disable_low <= bus.wdata;
      if (is_write(bus, acc_pkg::OFS_PIN_OFF_HI))
        pin_input_disable_high <= bus.wdata & acc_pkg::PIN_OFF_HI_MASK; // R19
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // result synchroniser and event detection

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_first        <= 1'b0;
      comparator_result <= 1'b0;
      result_prev       <= 1'b0;
    end else begin
      sync_first        <= comparator_raw;
      comparator_result <= sync_first;        // R04
      result_prev       <= comparator_result; // R20
    end
  end

  always_comb begin
    case (acc_pkg::acc_mode_e'(event_mode)) // R09
      acc_pkg::ACC_MODE_TOGGLE: event_hit = comparator_result ^ result_prev;
      acc_pkg::ACC_MODE_FALL:   event_hit = result_prev & ~comparator_result;
      acc_pkg::ACC_MODE_RISE:   event_hit = ~result_prev & comparator_result;
      default:                  event_hit = 1'b0; // R20
    endcase
  end

  assign flag_write_clear = is_write(bus, acc_pkg::OFS_CTRL_STATUS)
                          && bus.wdata[acc_pkg::BIT_FLAG];

  // a new event wins over a clear in the same cycle
  always_comb begin
    if (event_hit)
      next_flag = 1'b1; // R05
    else if (flag_write_clear || irq_vector_taken)
      next_flag = 1'b0; // R07
    else
      next_flag = comparator_event_flag;
  end

  always_ff @(posedge clk) begin
    if (reset)
      comparator_event_flag <= 1'b0;
    else
      comparator_event_flag <= next_flag;
  end

  assign irq_request = comparator_event_flag && comparator_irq_enable
                     && global_irq_enable; // R06

  //////////////////////////////////////////////////////////////////////////
  // analog steering

  always_comb begin
    analog               = '0;
    analog.power_off     = comparator_power_off;      // R01
    analog.bandgap_sel   = bandgap_positive_select;   // R03
    analog.hyst_on       = hysteresis_on;             // R11
    analog.hyst_large    = hysteresis_on && hysteresis_amount; // R12
    analog.neg_channel   = converter_channel_select;
    if (converter_mux_for_negative && !converter_on
        && converter_channel_select <= acc_pkg::CH_MAX) begin // R08
      analog.neg_from_conv = 1'b1; // R15
      if (comparator_input_select[2])
        analog.pos_pin = acc_pkg::PIN_TWO;
      else if (comparator_input_select[1])
        analog.pos_pin = acc_pkg::PIN_ONE;
      else
        analog.pos_pin = acc_pkg::PIN_ZERO;
    end else begin
      case (comparator_input_select) // R14
        3'h0: begin
          analog.pos_pin = acc_pkg::PIN_ZERO;
          analog.neg_pin = acc_pkg::PIN_ONE;
        end
        3'h1: begin
          analog.pos_pin = acc_pkg::PIN_ZERO;
          analog.neg_pin = acc_pkg::PIN_TWO;
        end
        3'h2: begin
          analog.pos_pin = acc_pkg::PIN_ONE;
          analog.neg_pin = acc_pkg::PIN_ZERO;
        end
        3'h3: begin
          analog.pos_pin = acc_pkg::PIN_ONE;
          analog.neg_pin = acc_pkg::PIN_TWO;
        end
        3'h4: begin
          analog.pos_pin = acc_pkg::PIN_TWO;
          analog.neg_pin = acc_pkg::PIN_ZERO;
        end
        default: begin
          analog.pos_pin = acc_pkg::PIN_TWO;
          analog.neg_pin = acc_pkg::PIN_ONE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // digital input buffer disables

  assign analog_pin_input_off = {pin_input_disable_high[7:4],
                                 pin_input_disable_low[7:4],
                                 pin_input_disable_low[2:0]}; // R16
  assign reference_pin_input_off = pin_input_disable_low[3];  // R17
  assign pin_digital_read = pin_digital_in & ~analog_pin_input_off; // R16
  assign reference_digital_read = reference_digital_in
                                & ~reference_pin_input_off;  // R17

  //////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    next_rdata = acc_pkg::RESET_BYTE;
    if (bus.rd) begin
      case (bus.addr)
        acc_pkg::OFS_PIN_OFF_LO:  next_rdata = pin_input_disable_low;
        acc_pkg::OFS_PIN_OFF_HI:  next_rdata = pin_input_disable_high;
        acc_pkg::OFS_CTRL_STATUS: next_rdata = {comparator_power_off,
          bandgap_positive_select, comparator_result, comparator_event_flag,
          comparator_irq_enable, converter_mux_for_negative, event_mode};
        acc_pkg::OFS_INPUT_HYST:  next_rdata = {hysteresis_on,
          hysteresis_amount, 3'h0, comparator_input_select};
        default:                  next_rdata = acc_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset)
      rdata <= acc_pkg::RESET_BYTE;
    else
      rdata <= next_rdata;
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  property p_sync_delay;
    @(posedge clk) disable iff (reset)
      comparator_result == $past(comparator_raw, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) // R04
    else $error("result not two cycles behind raw input");

  property p_flag_on_rise;
    @(posedge clk) disable iff (reset)
      (event_mode == 2'h3 && $rose(comparator_result))
        |=> comparator_event_flag;
  endproperty
  a_flag_on_rise: assert property (p_flag_on_rise) // R05
    else $error("rising edge did not set flag");

  property p_reserved_quiet;
    @(posedge clk) disable iff (reset)
      (event_mode == 2'h1 && !comparator_event_flag)
        |=> !comparator_event_flag;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) // R20
    else $error("reserved mode raised flag");

  property p_fall_only;
    @(posedge clk) disable iff (reset)
      (event_mode == 2'h2 && !comparator_event_flag
       && !(result_prev && !comparator_result)) |=> !comparator_event_flag;
  endproperty
  a_fall_only: assert property (p_fall_only) // R09
    else $error("falling mode set flag without falling edge");

  property p_irq;
    @(posedge clk) disable iff (reset)
      irq_request == (comparator_event_flag && comparator_irq_enable
                      && global_irq_enable);
  endproperty
  a_irq: assert property (p_irq) // R06
    else $error("irq request mismatch");

  property p_vector_clear;
    @(posedge clk) disable iff (reset)
      (irq_vector_taken && !event_hit) |=> !comparator_event_flag;
  endproperty
  a_vector_clear: assert property (p_vector_clear) // R07
    else $error("vector did not clear flag");

  property p_hi_low_nibble;
    @(posedge clk) disable iff (reset)
      pin_input_disable_high[3:0] == 4'h0;
  endproperty
  a_hi_low_nibble: assert property (p_hi_low_nibble) // R19
    else $error("upper disable register low nibble not zero");

  property p_pin_masked;
    @(posedge clk) disable iff (reset)
      (pin_digital_read & analog_pin_input_off) == 11'h000;
  endproperty
  a_pin_masked: assert property (p_pin_masked) // R16
    else $error("disabled pin reads one");

  property p_conv_neg;
    @(posedge clk) disable iff (reset)
      (converter_on || !converter_mux_for_negative) |-> !analog.neg_from_conv;
  endproperty
  a_conv_neg: assert property (p_conv_neg) // R08
    else $error("converter path used while not allowed");

  c_flag_toggle: cover property (@(posedge clk) disable iff (reset)
    event_mode == 2'h0 && $rose(comparator_event_flag));
  c_irq: cover property (@(posedge clk) disable iff (reset)
    $rose(irq_request));
  c_set_beats_clear: cover property (@(posedge clk) disable iff (reset)
    event_hit && flag_write_clear);

endmodule : acc_control

// file: hdl/acc_pkg.sv
// shared constants and types for the analog comparator control block
package acc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_PIN_OFF_LO  = 8'h01;
  localparam logic [7:0] OFS_PIN_OFF_HI  = 8'h02;
  localparam logic [7:0] OFS_CTRL_STATUS = 8'h08;
  localparam logic [7:0] OFS_INPUT_HYST  = 8'h09;

  // control/status field positions
  localparam int BIT_POWER_OFF  = 7;
  localparam int BIT_BANDGAP    = 6;
  localparam int BIT_RESULT     = 5;
  localparam int BIT_FLAG       = 4;
  localparam int BIT_IRQ_EN     = 3;
  localparam int BIT_MUX_NEG    = 2;
  localparam int BIT_MODE_HI    = 1;
  localparam int BIT_MODE_LO    = 0;

  // input/hysteresis field positions
  localparam int BIT_HYST_ON    = 7;
  localparam int BIT_HYST_AMT   = 6;
  localparam int SEL_W          = 3;

  // upper pin disable register keeps only its high nibble
  localparam logic [7:0] PIN_OFF_HI_MASK = 8'hF0;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [2:0] SEL_RESET       = 3'h0;

  // event mode codes
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE   = 2'h0,
    ACC_MODE_RESERVED = 2'h1,
    ACC_MODE_FALL     = 2'h2,
    ACC_MODE_RISE     = 2'h3
  } acc_mode_e;

  // pin selection codes for the analog multiplexers
  localparam logic [1:0] PIN_ZERO = 2'h0;
  localparam logic [1:0] PIN_ONE  = 2'h1;
  localparam logic [1:0] PIN_TWO  = 2'h2;
  localparam int CH_W             = 6;
  localparam logic [5:0] CH_MAX   = 6'h0A;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } acc_bus_s;

  // analog front end steering
  typedef struct packed {
    logic       power_off;
    logic       bandgap_sel;
    logic [1:0] pos_pin;
    logic       neg_from_conv;
    logic [1:0] neg_pin;
    logic [5:0] neg_channel;
    logic       hyst_on;
    logic       hyst_large;
  } acc_analog_s;

endpackage : acc_pkg
